// [hdl/hub_cfg_pkg.sv]
// package: offsets, ranges, reset values and bus timing for the hub string and charge registers
package hub_cfg_pkg;
  // ******************************
  // register offsets (byte offsets, index form)
  // ******************************
  localparam logic [7:0] LANGUAGE_ID_HIGH_OFS = 8'h11;
  localparam logic [7:0] LANGUAGE_ID_LOW_OFS = 8'h12;
  localparam logic [7:0] MAKER_TEXT_LENGTH_OFS = 8'h13;
  localparam logic [7:0] PRODUCT_TEXT_LENGTH_OFS = 8'h14;
  localparam logic [7:0] SERIAL_TEXT_LENGTH_OFS = 8'h15;
  localparam logic [7:0] MAKER_TEXT_FIRST = 8'h16;
  localparam logic [7:0] MAKER_TEXT_LAST = 8'h53;
  localparam logic [7:0] PRODUCT_TEXT_FIRST = 8'h54;
  localparam logic [7:0] PRODUCT_TEXT_LAST = 8'h91;
  localparam logic [7:0] SERIAL_TEXT_FIRST = 8'h92;
  localparam logic [7:0] SERIAL_TEXT_LAST = 8'hCF;
  localparam logic [7:0] CHARGE_PORT_ENABLE_OFS = 8'hD0;
  // ******************************
  // fields and values
  // ******************************
  localparam int TEXT_BYTES = 62;
  localparam int TEXT_MAX_CHARS = 31;
  localparam logic [7:0] CHARGE_PORT_MASK = 8'h1E;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TEXT_LENGTH_MAX = 8'h1F;
  localparam int NUM_PORTS = 4;
  localparam int BUS_AW = 10;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // ******************************
  // bus phases
  // ******************************
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// [hdl/text_store.sv]
// byte store for one descriptor string, utf-16le, low byte at the lower address
module text_store
  import hub_cfg_pkg::*;
#(
  parameter int DEPTH = TEXT_BYTES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic [5:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [5:0] i_raddr,
  output logic [7:0] o_rdata,
  input wire logic [4:0] i_char_idx,
  output logic [15:0] o_char
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];
  logic [5:0] lo_idx;

  // ******************************
  // storage, one generate per entry
  // ******************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_byte
      always_comb begin
        mem_d[g] = mem_q[g];
        if (i_wr && i_waddr == 6'(g)) begin
          mem_d[g] = i_wdata;
        end
      end
      always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
          mem_q[g] <= REG_RESET;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  assign o_rdata = (i_raddr < 6'(DEPTH)) ? mem_q[i_raddr] : REG_RESET;
  // character n: low byte at 2n, high byte at 2n+1
  assign lo_idx = {i_char_idx, 1'b0};
  assign o_char = (lo_idx < 6'(DEPTH)) ? {mem_q[lo_idx | 6'h01], mem_q[lo_idx]} : 16'h0000;
endmodule

// [hdl/charge_mask.sv]
// battery charging enable mask, reserved bits held at zero
module charge_mask
  import hub_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_value
);
  logic [7:0] mask_q;
  logic [7:0] mask_d;

  always_comb begin
    mask_d = mask_q;
    if (i_wr) begin
      mask_d = i_wdata & CHARGE_PORT_MASK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mask_q <= REG_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  assign o_value = mask_q;
endmodule

// [hdl/hub_string_and_charge_config.sv]
// register bank for language id, string descriptors and per-port charge enable
// Operation
// - the language id high byte comes from the full register at 0x11.
// - the language id low byte comes from the full register at 0x12.
// - the register at 0x13 holds the maker string length, up to 31 characters; any 8-bit value is stored as written, with no clamp.
// - the register at 0x14 holds the product string length, up to 31 characters; any 8-bit value is stored as written, with no clamp.
// - the register at 0x15 holds the serial string length, up to 31 characters; any 8-bit value is stored as written, with no clamp.
// - maker string bytes live at 0x16 through 0x53.
// - product string bytes live at 0x54 through 0x91, at most 62 bytes.
// - serial string bytes live at 0x92 through 0xCF.
// - each character is a 16-bit little-endian utf-16 code unit.
// - a character takes two bytes, low first, characters following contiguously.
// - each charge enable bit turns charging on for its port when 1, off when 0.
// - charge enable bits 1 to 4 drive ports 1 to 4, bits 0 and 5 to 7 are reserved.
//
// Implementation choice: register access over Avalon-MM.
module hub_string_and_charge_config
  import hub_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [hub_cfg_pkg::BUS_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  output logic [15:0] o_language_id,
  output logic [7:0] o_maker_text_length,
  output logic [7:0] o_product_text_length,
  output logic [7:0] o_serial_text_length,
  input wire logic [4:0] i_char_idx,
  output logic [15:0] o_maker_char,
  output logic [15:0] o_product_char,
  output logic [15:0] o_serial_char,
  output logic [hub_cfg_pkg::NUM_PORTS:1] o_charge_enable
);
  import hub_cfg_pkg::*;

  // ******************************
  // bus slave
  // ******************************
  // one wait cycle per access: the request is decoded in BUS_IDLE and
  // answered in BUS_ACK, so read data always come from a flip-flop
  bus_state_t state_q;
  bus_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] resp_q;
  logic [1:0] resp_d;
  logic [7:0] idx;
  logic lane0;
  logic hit_regs;
  logic in_maker;
  logic in_product;
  logic in_serial;
  logic do_wr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic mapped;

  assign idx = i_avs_address[BUS_AW-1:2] < 8'hFF ? i_avs_address[9:2] : 8'hFF;
  assign lane0 = i_avs_address[1:0] == 2'h0;
  assign in_maker = idx >= MAKER_TEXT_FIRST && idx <= MAKER_TEXT_LAST;
  assign in_product = idx >= PRODUCT_TEXT_FIRST && idx <= PRODUCT_TEXT_LAST;
  assign in_serial = idx >= SERIAL_TEXT_FIRST && idx <= SERIAL_TEXT_LAST;
  assign hit_regs = (idx >= LANGUAGE_ID_HIGH_OFS && idx <= SERIAL_TEXT_LENGTH_OFS)
                    || idx == CHARGE_PORT_ENABLE_OFS;
  assign mapped = lane0 && (hit_regs || in_maker || in_product || in_serial);
  // writes land only in the cycle the slave accepts them
  assign do_wr = state_q == BUS_IDLE && i_avs_write && mapped && i_avs_byteenable[0];
  assign wbyte = i_avs_writedata[7:0];

  // ******************************
  // plain byte registers
  // ******************************
  logic [7:0] lang_hi_q;
  logic [7:0] lang_hi_d;
  logic [7:0] lang_lo_q;
  logic [7:0] lang_lo_d;
  logic [7:0] maker_len_q;
  logic [7:0] maker_len_d;
  logic [7:0] product_len_q;
  logic [7:0] product_len_d;
  logic [7:0] serial_len_q;
  logic [7:0] serial_len_d;

  always_comb begin
    lang_hi_d = lang_hi_q;
    lang_lo_d = lang_lo_q;
    maker_len_d = maker_len_q;
    product_len_d = product_len_q;
    serial_len_d = serial_len_q;
    if (do_wr) begin
      case (idx)
        LANGUAGE_ID_HIGH_OFS: lang_hi_d = wbyte;
        LANGUAGE_ID_LOW_OFS: lang_lo_d = wbyte;
        MAKER_TEXT_LENGTH_OFS: maker_len_d = wbyte;
        PRODUCT_TEXT_LENGTH_OFS: product_len_d = wbyte;
        SERIAL_TEXT_LENGTH_OFS: serial_len_d = wbyte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lang_hi_q <= REG_RESET;
      lang_lo_q <= REG_RESET;
      maker_len_q <= REG_RESET;
      product_len_q <= REG_RESET;
      serial_len_q <= REG_RESET;
    end else begin
      lang_hi_q <= lang_hi_d;
      lang_lo_q <= lang_lo_d;
      maker_len_q <= maker_len_d;
      product_len_q <= product_len_d;
      serial_len_q <= serial_len_d;
    end
  end

  assign o_language_id = {lang_hi_q, lang_lo_q};
  // lengths are stored as written; a value above 31 is the writer's fault
  assign o_maker_text_length = maker_len_q;
  assign o_product_text_length = product_len_q;
  assign o_serial_text_length = serial_len_q;

  // ******************************
  // string stores and charge mask
  // ******************************
  logic [7:0] maker_rd;
  logic [7:0] product_rd;
  logic [7:0] serial_rd;
  logic [7:0] charge_val;
  logic [5:0] maker_ofs;
  logic [5:0] product_ofs;
  logic [5:0] serial_ofs;

  assign maker_ofs = 6'(idx - MAKER_TEXT_FIRST);
  assign product_ofs = 6'(idx - PRODUCT_TEXT_FIRST);
  assign serial_ofs = 6'(idx - SERIAL_TEXT_FIRST);

  text_store #(.DEPTH(TEXT_BYTES)) u_maker (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_wr(do_wr && in_maker),
    .i_waddr(maker_ofs),
    .i_wdata(wbyte),
    .i_raddr(maker_ofs),
    .o_rdata(maker_rd),
    .i_char_idx(i_char_idx),
    .o_char(o_maker_char)
  );

  text_store #(.DEPTH(TEXT_BYTES)) u_product (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_wr(do_wr && in_product),
    .i_waddr(product_ofs),
    .i_wdata(wbyte),
    .i_raddr(product_ofs),
    .o_rdata(product_rd),
    .i_char_idx(i_char_idx),
    .o_char(o_product_char)
  );

  text_store #(.DEPTH(TEXT_BYTES)) u_serial (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_wr(do_wr && in_serial),
    .i_waddr(serial_ofs),
    .i_wdata(wbyte),
    .i_raddr(serial_ofs),
    .o_rdata(serial_rd),
    .i_char_idx(i_char_idx),
    .o_char(o_serial_char)
  );

  charge_mask u_charge (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_wr(do_wr && idx == CHARGE_PORT_ENABLE_OFS),
    .i_wdata(wbyte),
    .o_value(charge_val)
  );

  assign o_charge_enable = charge_val[NUM_PORTS:1];

  // ******************************
  // read mux and answer
  // ******************************
  always_comb begin
    rd_byte = REG_RESET;
    if (in_maker) begin
      rd_byte = maker_rd;
    end else if (in_product) begin
      rd_byte = product_rd;
    end else if (in_serial) begin
      rd_byte = serial_rd;
    end else begin
      case (idx)
        LANGUAGE_ID_HIGH_OFS: rd_byte = lang_hi_q;
        LANGUAGE_ID_LOW_OFS: rd_byte = lang_lo_q;
        MAKER_TEXT_LENGTH_OFS: rd_byte = maker_len_q;
        PRODUCT_TEXT_LENGTH_OFS: rd_byte = product_len_q;
        SERIAL_TEXT_LENGTH_OFS: rd_byte = serial_len_q;
        CHARGE_PORT_ENABLE_OFS: rd_byte = charge_val;
        default: rd_byte = REG_RESET;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    resp_d = resp_q;
    case (state_q)
      BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          state_d = BUS_ACK;
          // unmapped or unaligned access answers slave error, reads zero
          resp_d = mapped ? 2'h0 : 2'h2;
          rdata_d = (i_avs_read && mapped) ? {24'h000000, rd_byte} : UNMAPPED_READ;
        end
      end
      BUS_ACK: state_d = BUS_IDLE;
      default: state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q <= BUS_IDLE;
      rdata_q <= UNMAPPED_READ;
      resp_q <= 2'h0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  assign o_avs_waitrequest = !(state_q == BUS_ACK);
  assign o_avs_readdata = rdata_q;
  assign o_avs_response = resp_q;

  // ******************************
  // checks
  // ******************************
  AST_LANG_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == LANGUAGE_ID_HIGH_OFS |=> o_language_id[15:8] == $past(wbyte))
    else $error("language id high byte not taken");
  AST_LANG_LOW: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == LANGUAGE_ID_LOW_OFS |=> o_language_id[7:0] == $past(wbyte))
    else $error("language id low byte not taken");
  AST_MAKER_LEN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == MAKER_TEXT_LENGTH_OFS |=> o_maker_text_length == $past(wbyte))
    else $error("maker length not stored");
  AST_PRODUCT_LEN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == PRODUCT_TEXT_LENGTH_OFS |=> o_product_text_length == $past(wbyte))
    else $error("product length not stored");
  AST_SERIAL_LEN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == SERIAL_TEXT_LENGTH_OFS |=> o_serial_text_length == $past(wbyte))
    else $error("serial length not stored");
  AST_MAKER_CHAR: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == MAKER_TEXT_FIRST && i_char_idx == 5'h00 ##1 i_char_idx == 5'h00
    |-> o_maker_char[7:0] == $past(wbyte))
    else $error("maker low byte misplaced");
  AST_PRODUCT_CHAR: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == 8'h55 ##1 i_char_idx == 5'h00
    |-> o_product_char[15:8] == $past(wbyte))
    else $error("product high byte misplaced");
  AST_SERIAL_CHAR: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == SERIAL_TEXT_LAST ##1 i_char_idx == 5'h1E
    |-> o_serial_char[15:8] == $past(wbyte))
    else $error("serial last byte misplaced");
  AST_CHARGE_MAP: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    do_wr && idx == CHARGE_PORT_ENABLE_OFS |=> o_charge_enable == $past(wbyte[4:1]))
    else $error("charge enable not mapped to ports");
  AST_CHARGE_RSVD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (charge_val & ~CHARGE_PORT_MASK) == 8'h00)
    else $error("reserved charge bits set");
  // read answers carry the register as it stood when the request was taken
  AST_RD_LANG_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_q == BUS_IDLE && i_avs_read && mapped && idx == LANGUAGE_ID_HIGH_OFS
    |=> o_avs_readdata == {24'h000000, $past(lang_hi_q)})
    else $error("language id high byte not read back");
  AST_RD_LANG_LOW: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_q == BUS_IDLE && i_avs_read && mapped && idx == LANGUAGE_ID_LOW_OFS
    |=> o_avs_readdata == {24'h000000, $past(lang_lo_q)})
    else $error("language id low byte not read back");
  AST_RD_MAKER: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_q == BUS_IDLE && i_avs_read && mapped && in_maker
    |=> o_avs_readdata[7:0] == $past(maker_rd))
    else $error("maker string byte not read back");
  AST_RD_RSVD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_q == BUS_IDLE && i_avs_read && mapped && idx == CHARGE_PORT_ENABLE_OFS
    |=> (o_avs_readdata[7:0] & ~CHARGE_PORT_MASK) == 8'h00)
    else $error("reserved charge bits read nonzero");
  AST_REFUSED: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_q == BUS_IDLE && (i_avs_read || i_avs_write) && !mapped
    |=> o_avs_response == 2'h2 && o_avs_readdata == UNMAPPED_READ)
    else $error("unmapped access not refused");
  AST_BUS_ANSWER: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_q == BUS_IDLE && (i_avs_read || i_avs_write) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle after request");
endmodule

// [tb/cfg_master.sv]
// bus master model standing in for the configuration source
module cfg_master
  import hub_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  input wire logic [1:0] i_response,
  output logic [hub_cfg_pkg::BUS_AW-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_address = '0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = '0;
    o_byteenable = 4'h0;
  end
  // ******************************
  // one access, held until waitrequest is seen low at a rising edge
  // ******************************
  task automatic access(input logic wr, input logic [9:0] addr, input logic [7:0] data,
      input logic [3:0] be, output logic [31:0] rd, output logic [1:0] resp);
    logic busy;
    @(posedge i_sys_clk);
    o_address <= addr;
    o_read <= !wr;
    o_write <= wr;
    o_writedata <= {24'h5A5A5A, data};
    o_byteenable <= be;
    // sampled at the rising edge, before the slave's own update at that edge lands
    do begin
      @(posedge i_sys_clk);
      busy = i_waitrequest;
      rd = i_readdata;
      resp = i_response;
    end while (busy !== 1'b0);
    o_read <= 1'b0;
    o_write <= 1'b0;
    // released address and write data show junk, never the last value; byteenable keeps its last value
    o_address <= ~addr;
    o_writedata <= ~o_writedata;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the hub string and charge register bank
module tb;
  import hub_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_srst, avs_read, avs_write, avs_waitrequest;
  logic [BUS_AW-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response;
  logic [15:0] language_id, maker_char, product_char, serial_char;
  logic [7:0] maker_len, product_len, serial_len, v;
  logic [4:0] char_idx;
  logic [NUM_PORTS:1] charge_enable;
  logic [7:0] mem [256];
  int error_cnt, n_checks;

  hub_string_and_charge_config u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .o_avs_response(avs_response), .o_language_id(language_id),
    .o_maker_text_length(maker_len), .o_product_text_length(product_len),
    .o_serial_text_length(serial_len), .i_char_idx(char_idx), .o_maker_char(maker_char),
    .o_product_char(product_char), .o_serial_char(serial_char),
    .o_charge_enable(charge_enable));
  cfg_master u_master (.i_sys_clk(i_sys_clk), .i_waitrequest(avs_waitrequest),
    .i_readdata(avs_readdata), .i_response(avs_response), .o_address(avs_address),
    .o_read(avs_read), .o_write(avs_write), .o_writedata(avs_writedata),
    .o_byteenable(avs_byteenable));

  // ******************************
  // expectations and comparisons
  // ******************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic mapped(input logic [7:0] idx);
    return idx >= LANGUAGE_ID_HIGH_OFS && idx <= CHARGE_PORT_ENABLE_OFS;
  endfunction
  function automatic logic [15:0] exp_char(input int start, input int n);
    return (n >= TEXT_MAX_CHARS) ? 16'h0000 : {mem[start + 2 * n + 1], mem[start + 2 * n]};
  endfunction
  task automatic note(input logic ok, input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bus(input logic [33:0] got, input logic [33:0] exp);
    note(got === exp, got, exp);
  endtask
  task automatic check_port(input logic [15:0] got, input logic [15:0] exp);
    note(got === exp, 34'(got), 34'(exp));
  endtask
  task automatic reg_write(input logic [9:0] addr, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] rd;
    logic [1:0] resp;
    logic ok;
    ok = (addr[1:0] == 2'b00) && mapped(addr[9:2]);
    u_master.access(1'b1, addr, d, be, rd, resp);
    if (ok && be[0]) begin
      mem[addr[9:2]] = (addr[9:2] == CHARGE_PORT_ENABLE_OFS) ? (d & CHARGE_PORT_MASK) : d;
    end
    check_bus({resp, 32'h0}, {ok ? 2'b00 : 2'b10, 32'h0});
  endtask
  task automatic reg_read(input logic [9:0] addr);
    logic [31:0] rd;
    logic [1:0] resp;
    logic ok;
    ok = (addr[1:0] == 2'b00) && mapped(addr[9:2]);
    u_master.access(1'b0, addr, 8'h00, 4'hF, rd, resp);
    check_bus({resp, rd}, ok ? {2'b00, 24'h0, mem[addr[9:2]]} : {2'b10, 32'h0});
  endtask
  task automatic readback_all();
    // spans one unmapped index on each side of the bank
    for (int i = 16; i <= 209; i++) reg_read(10'(i * 4));
  endtask
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    foreach (mem[i]) mem[i] = REG_RESET;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check_port({13'h0, avs_waitrequest, avs_response}, 16'h0004);
    @(posedge i_sys_clk);
    i_srst <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ******************************
  // clock, watchdog and test sequence
  // ******************************
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #(10000 * 100);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    i_srst = 1'b1;
    char_idx = 5'h00;
    seed = 32'hf9aa;
    error_cnt = 0;
    n_checks = 0;
    do_reset();
    readback_all();
    $display("test reset values done");
    seed = xorshift(seed);
    reg_write(10'h044, seed[7:0], 4'hF);
    reg_write(10'h048, seed[15:8], 4'hF);
    reg_write(10'h045, 8'hEE, 4'hF);
    reg_write(10'h044, 8'h77, 4'h0);
    reg_write(10'h040, 8'h66, 4'hF);
    check_port(language_id, {mem[8'h11], mem[8'h12]});
    // lengths kept within 31 characters, edges included
    reg_write(10'h04C, 8'h1F, 4'hF);
    reg_write(10'h050, 8'h00, 4'hF);
    reg_write(10'h054, {3'b000, seed[20:16]}, 4'hF);
    check_port({maker_len, product_len}, {mem[8'h13], mem[8'h14]});
    check_port({8'h00, serial_len}, {8'h00, mem[8'h15]});
    $display("test language and lengths done");
    // each character sent low byte first, characters back to back
    for (int s = 0; s < 3; s++) begin
      for (int b = 0; b < TEXT_BYTES; b++) begin
        // serial bytes go in while the last character is shown
        if (s == 2 && b == 0) begin
          char_idx <= 5'(TEXT_MAX_CHARS - 1);
        end
        seed = xorshift(seed);
        reg_write(10'((MAKER_TEXT_FIRST + s * TEXT_BYTES + b) * 4), seed[7:0], 4'hF);
      end
    end
    for (int n = 0; n < 32; n++) begin
      @(posedge i_sys_clk);
      char_idx <= 5'(n);
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check_port(maker_char, exp_char(MAKER_TEXT_FIRST, n));
      check_port(product_char, exp_char(PRODUCT_TEXT_FIRST, n));
      check_port(serial_char, exp_char(SERIAL_TEXT_FIRST, n));
    end
    $display("test strings done");
    for (int k = 0; k < 4; k++) begin
      seed = xorshift(seed);
      v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : seed[7:0];
      reg_write(10'h340, v, 4'hF);
      check_port({12'h000, charge_enable}, {12'h000, v[4:1]});
      reg_read(10'h340);
    end
    $display("test charge enable done");
    readback_all();
    do_reset();
    check_port(language_id, 16'h0000);
    readback_all();
    $display("test final readback and second reset done");
    tally_and_finish();
  end
endmodule
